// *** rtl/spc_pkg.sv ***
// constants shared by the control/status bank 0 design
package spc_pkg;

	// ==========================================================
	// frame and clock
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned CNT_W      = 5;
	localparam int unsigned CLK_NS     = 25;
	localparam int unsigned NUM_DRV    = 8;
	localparam int unsigned NUM_HB     = 3;
	localparam int unsigned SYN_W      = 17;
	localparam logic [SYN_W-1:0] SYN_RST = 17'h0_0001;

	// ==========================================================
	// control word 0 field positions
	localparam int unsigned C_SEL   = 0;
	localparam int unsigned C_DRV   = 1;
	localparam int unsigned C_CM    = 9;
	localparam int unsigned C_UVDIS = 12;
	localparam int unsigned C_DUTY  = 13;
	localparam int unsigned C_OLDIS = 14;
	localparam int unsigned C_CLR   = 15;
	localparam logic [15:0] CTRL0_RST = 16'h0000;

	// ==========================================================
	// status word 0 field positions
	localparam int unsigned S_FF  = 0;
	localparam int unsigned S_OC  = 1;
	localparam int unsigned S_NR  = 10;
	localparam int unsigned S_TW  = 11;
	localparam int unsigned S_TSD = 12;
	localparam int unsigned S_UV  = 13;
	localparam int unsigned S_OV  = 14;
	localparam logic [15:0] STAT1_OL_MASK = 16'h01fe;

	// ==========================================================
	// current monitor map: code -> driver number (0 = none)
	localparam int unsigned CM_W = 3;
	localparam logic [23:0] CM_MAP = 24'h00_58d1;

	// ==========================================================
	// timing
	localparam int unsigned STARTUP_US  = 100;
	localparam int unsigned RETRY_US    = 100;
	localparam int unsigned STARTUP_CYC_DEF = (STARTUP_US * 1000) / CLK_NS;
	localparam int unsigned RETRY_CYC_DEF   = (RETRY_US * 1000) / CLK_NS;

endpackage

// *** rtl/spc_drv_if.sv ***
// per-driver overcurrent retry signals between bank and retry timer
`timescale 1ns/1ps
interface spc_drv_if;
	logic oc_evt;
	logic retry_en;
	logic duty_low;
	logic oc_flag;
	logic allow;
	modport ctl (output oc_evt, output retry_en, output duty_low, output oc_flag, input allow);
	modport drv (input oc_evt, input retry_en, input duty_low, input oc_flag, output allow);
endinterface

// *** rtl/spc_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module spc_sync #(
	parameter int unsigned  W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			meta_reg <= RST;
			dout     <= RST;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule // spc_sync

// *** rtl/spc_retry.sv ***
// overcurrent retry timer for one driver
`timescale 1ns/1ps
module spc_retry
	import spc_pkg::*;
#(
	parameter int unsigned PERIOD = RETRY_CYC_DEF
) (
	input  wire logic mclk,
	input  wire logic nrst,
	spc_drv_if.drv    port
);
	localparam int unsigned W = $clog2(PERIOD + 1);
	localparam logic [W-1:0] OFF_LOW  = W'(PERIOD - PERIOD / 8);
	localparam logic [W-1:0] OFF_HIGH = W'(PERIOD - PERIOD / 4);

	logic [W-1:0] cnt_reg;

	// off time after a trip sets the duty: 1/8 or 1/4 of the period on
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (port.oc_evt && cnt_reg == '0) begin
			cnt_reg <= port.duty_low ? OFF_LOW : OFF_HIGH;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// without retry only a host clear of the flag frees the driver
	assign port.allow = port.retry_en ? (cnt_reg == '0) : !port.oc_flag;
endmodule // spc_retry

// *** rtl/spc_bank0.sv ***
// control word 0 / status word 0 bank with serial frame access
`timescale 1ns/1ps
module spc_bank0
	import spc_pkg::*;
#(
	parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF,
	parameter int unsigned RETRY_CYC   = RETRY_CYC_DEF
) (
	input  wire logic                mclk,
	input  wire logic                nrst,
	input  wire logic                frame_select_low,
	input  wire logic                sclk,
	input  wire logic                sdi,
	output logic                     sdo_o,
	output logic                     sdo_oe,
	input  wire logic                pwm_in,
	input  wire logic                active_req,
	input  wire logic                ov_in,
	input  wire logic                uv_in,
	input  wire logic                tsd_in,
	input  wire logic                warn_in,
	input  wire logic [NUM_DRV-1:0]  oc_in,
	input  wire logic [NUM_DRV-1:0]  pwm_enable,
	input  wire logic [NUM_DRV-1:0]  retry_enable,
	input  wire logic [15:0]         status_word_1,
	output logic [NUM_DRV-1:0]       drv_on,
	output logic [CM_W-1:0]          current_image_pin,
	output logic [15:0]              control_word_1,
	output logic                     control_word_1_wr,
	output logic                     status_clear,
	output logic [15:0]              status_word_0
);

	// ==========================================================
	// pin synchronisation
	logic [SYN_W-1:0]   syn_raw;
	logic [SYN_W-1:0]   syn;
	logic               csn_s;
	logic               sclk_s;
	logic               sdi_s;
	logic               pwm_s;
	logic               act_s;
	logic               ov_s;
	logic               uv_s;
	logic               tsd_s;
	logic               tw_s;
	logic [NUM_DRV-1:0] oc_s;

	assign syn_raw = {oc_in, warn_in, tsd_in, uv_in, ov_in, active_req, pwm_in, sdi, sclk,
		frame_select_low};

	spc_sync #(
		.W   (SYN_W),
		.RST (SYN_RST)
	) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.din  (syn_raw),
		.dout (syn)
	);

	assign csn_s  = syn[0];
	assign sclk_s = syn[1];
	assign sdi_s  = syn[2];
	assign pwm_s  = syn[3];
	assign act_s  = syn[4];
	assign ov_s   = syn[5];
	assign uv_s   = syn[6];
	assign tsd_s  = syn[7];
	assign tw_s   = syn[8];
	assign oc_s   = syn[16:9];

	// ==========================================================
	// edge detection
	logic csn_d_reg;
	logic sclk_d_reg;
	logic act_d_reg;
	logic csn_fall;
	logic csn_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic act_rise;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			csn_d_reg  <= 1'b1;
			sclk_d_reg <= 1'b0;
			act_d_reg  <= 1'b0;
		end else begin
			csn_d_reg  <= csn_s;
			sclk_d_reg <= sclk_s;
			act_d_reg  <= act_s;
		end
	end

	assign csn_fall  = csn_d_reg && !csn_s;
	assign csn_rise  = !csn_d_reg && csn_s;
	assign sclk_rise = !sclk_d_reg && sclk_s && !csn_s;
	assign sclk_fall = sclk_d_reg && !sclk_s && !csn_s;
	assign act_rise  = !act_d_reg && act_s;

	// ==========================================================
	// input shift register, lsb first
	logic [15:0]      shin_reg;
	logic [CNT_W-1:0] bitcnt_reg;
	logic             frame_ok;
	logic             wr_word0;
	logic             clr;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			shin_reg   <= '0;
			bitcnt_reg <= '0;
		end else if (csn_fall) begin
			bitcnt_reg <= '0;
		end else if (sclk_rise) begin
			shin_reg <= {sdi_s, shin_reg[15:1]};
			// saturate so that any count above 16 stays invalid
			if (bitcnt_reg != {CNT_W{1'b1}}) begin
				bitcnt_reg <= bitcnt_reg + 1'b1;
			end
		end
	end

	// a frame of any length other than 16 is dropped whole
	assign frame_ok = csn_rise && (bitcnt_reg == CNT_W'(FRAME_BITS));
	assign wr_word0 = frame_ok && !shin_reg[C_SEL];
	assign clr      = wr_word0 && shin_reg[C_CLR];

	// ==========================================================
	// control words
	logic [15:0] ctrl0_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl0_reg <= CTRL0_RST;
		end else if (wr_word0) begin
			ctrl0_reg <= shin_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			control_word_1    <= '0;
			control_word_1_wr <= 1'b0;
			status_clear      <= 1'b0;
		end else begin
			control_word_1_wr <= frame_ok && shin_reg[C_SEL];
			status_clear      <= clr;
			if (frame_ok && shin_reg[C_SEL]) begin
				control_word_1 <= shin_reg;
			end
		end
	end

	// ==========================================================
	// sticky status flags: a new event wins over a clear
	logic               ov_f_reg;
	logic               uv_f_reg;
	logic               tsd_f_reg;
	logic               tw_f_reg;
	logic [NUM_DRV-1:0] oc_f_reg;
	logic [NUM_DRV-1:0] oc_evt;

	// a trip only counts while the driver is actually on
	assign oc_evt = oc_s & drv_on;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ov_f_reg  <= 1'b0;
			uv_f_reg  <= 1'b0;
			tsd_f_reg <= 1'b0;
			tw_f_reg  <= 1'b0;
			oc_f_reg  <= '0;
		end else begin
			ov_f_reg  <= (ov_f_reg && !clr) || ov_s;
			uv_f_reg  <= (uv_f_reg && !clr) || uv_s;
			tsd_f_reg <= (tsd_f_reg && !clr) || tsd_s;
			tw_f_reg  <= (tw_f_reg && !clr) || tw_s;
			oc_f_reg  <= (oc_f_reg & {NUM_DRV{!clr}}) | oc_evt;
		end
	end

	// ==========================================================
	// startup timer after leaving standby
	localparam int unsigned SU_W = $clog2(STARTUP_CYC + 1);
	localparam logic [SU_W-1:0] SU_LOAD = SU_W'(STARTUP_CYC - 1);

	logic            nr_reg;
	logic [SU_W-1:0] su_cnt_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			nr_reg     <= 1'b0;
			su_cnt_reg <= '0;
		end else if (act_rise) begin
			nr_reg     <= 1'b1;
			su_cnt_reg <= SU_LOAD;
		end else if (nr_reg) begin
			if (su_cnt_reg == '0) begin
				nr_reg <= 1'b0;
			end else begin
				su_cnt_reg <= su_cnt_reg - 1'b1;
			end
		end
	end

	// ==========================================================
	// status word assembly and fault-free flag
	logic [14:1] flags0;
	logic [14:1] flags1;
	logic        fault_free_flag;
	logic [15:0] stat0;

	assign flags0 = {ov_f_reg, uv_f_reg, tsd_f_reg, tw_f_reg, nr_reg, 1'b0, oc_f_reg};
	assign flags1 = ctrl0_reg[C_OLDIS] ? (status_word_1[14:1] & ~STAT1_OL_MASK[14:1])
		: status_word_1[14:1];
	assign fault_free_flag = ~|(flags0 | flags1);
	assign stat0 = {1'b1, flags0, fault_free_flag};

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			status_word_0 <= '0;
		end else begin
			status_word_0 <= stat0;
		end
	end

	// ==========================================================
	// output shift register and data out pin
	logic [15:0] shout_reg;
	logic        started_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			shout_reg   <= '0;
			started_reg <= 1'b0;
		end else if (csn_fall) begin
			started_reg <= 1'b0;
		end else if (sclk_rise && bitcnt_reg == '0) begin
			// the select bit arrives on this same edge
			shout_reg   <= sdi_s ? status_word_1 : stat0;
			started_reg <= 1'b1;
		end else if (sclk_fall && started_reg) begin
			shout_reg <= {1'b0, shout_reg[15:1]};
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sdo_o  <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_o  <= started_reg ? shout_reg[0] : fault_free_flag;
			sdo_oe <= !csn_s;
		end
	end

	// ==========================================================
	// overcurrent retry timers
	logic [NUM_DRV-1:0] allow;
	logic               duty_low;

	assign duty_low = !ctrl0_reg[C_DUTY] || tw_f_reg;

	for (genvar i = 0; i < NUM_DRV; i++) begin : g_retry
		spc_drv_if dif ();
		assign dif.oc_evt   = oc_evt[i];
		assign dif.retry_en = retry_enable[i];
		assign dif.duty_low = duty_low;
		assign dif.oc_flag  = oc_f_reg[i];
		assign allow[i]     = dif.allow;
		spc_retry #(
			.PERIOD (RETRY_CYC)
		) u_retry (
			.mclk (mclk),
			.nrst (nrst),
			.port (dif)
		);
	end

	// ==========================================================
	// output drive
	logic               supply_blk;
	logic               blk;
	logic [NUM_DRV-1:0] want;
	logic [NUM_DRV-1:0] safe;

	// with recovery enabled only the live supply state blocks
	assign supply_blk = ov_s || uv_s
		|| (ctrl0_reg[C_UVDIS] && (ov_f_reg || uv_f_reg));
	// the warning flag is left out here on purpose
	// act_rise closes the one-cycle gap before the not-ready flag lands
	assign blk = !act_s || act_rise || nr_reg || tsd_f_reg || tsd_s || supply_blk;

	always_comb begin
		want = ctrl0_reg[C_DRV +: NUM_DRV] & allow;
		want = want & (~pwm_enable | {NUM_DRV{pwm_s}});
		safe = want;
		// both bits of a half-bridge set: neither side is turned on
		for (int b = 0; b < NUM_HB; b++) begin
			if (want[2*b] && want[2*b+1]) begin
				safe[2*b]   = 1'b0;
				safe[2*b+1] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			drv_on <= '0;
		end else begin
			drv_on <= blk ? '0 : safe;
		end
	end

	// ==========================================================
	// current monitor routing
	logic [CM_W-1:0] cm_code;

	assign cm_code = ctrl0_reg[C_CM +: CM_W];

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			current_image_pin <= '0;
		end else begin
			current_image_pin <= CM_MAP[CM_W*cm_code +: CM_W];
		end
	end

endmodule // spc_bank0

// *** verif/spc_bank0_monitor.sv ***
// assertion checker for the bank 0 control/status ports
`timescale 1ns/1ps
module spc_bank0_monitor
	import spc_pkg::*;
#(
	parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF,
	parameter int unsigned RETRY_CYC   = RETRY_CYC_DEF
) (
	input wire logic               mclk,
	input wire logic               nrst,
	input wire logic               ov_in,
	input wire logic [NUM_DRV-1:0] drv_on,
	input wire logic [15:0]        control_word_1,
	input wire logic               control_word_1_wr,
	input wire logic               status_clear,
	input wire logic [15:0]        status_word_0
);
	// ==========================================================
	// port properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_marker; $past(nrst, 2) |-> status_word_0[15]; endproperty
	a_marker: assert property (p_marker) else $error("status top bit low");
	property p_unused; status_word_0[9] == 1'b0; endproperty
	a_unused: assert property (p_unused) else $error("status bit 9 set");
	property p_ffree; |status_word_0[14:1] |-> !status_word_0[S_FF]; endproperty
	a_ffree: assert property (p_ffree) else $error("fault-free flag set with flags");
	// two-cycle settle: flag and driver register may land on different edges
	property p_hot; status_word_0[S_TSD] && $past(status_word_0[S_TSD], 2) |-> drv_on == '0;
	endproperty
	a_hot: assert property (p_hot) else $error("driver on in thermal trip");
	// status lags the driver register, so the cycle before must be off as well
	property p_nrdy; status_word_0[S_NR] |-> drv_on == '0 && $past(drv_on) == '0;
	endproperty
	a_nrdy: assert property (p_nrdy) else $error("driver on while not ready");
	property p_bridge;
		!(drv_on[0] && drv_on[1]) && !(drv_on[2] && drv_on[3]) && !(drv_on[4] && drv_on[5]);
	endproperty
	a_bridge: assert property (p_bridge) else $error("half-bridge shoot-through");
	// two sync stages and the driver register lie between pin and output
	property p_supply; ov_in && $past(ov_in) && $past(ov_in, 2) && $past(ov_in, 3)
		|-> drv_on == '0; endproperty
	a_supply: assert property (p_supply) else $error("driver on in overvoltage");
	property p_clear; status_clear |-> ##[0:1] status_word_0[14:11] == 4'h0; endproperty
	a_clear: assert property (p_clear) else $error("flags survive clear");
	property p_cw1; $changed(control_word_1) |-> control_word_1_wr; endproperty
	a_cw1: assert property (p_cw1) else $error("word 1 changed without strobe");
	property p_clrpulse; status_clear |=> !status_clear; endproperty
	a_clrpulse: assert property (p_clrpulse) else $error("clear pulse too long");
endmodule // spc_bank0_monitor

bind spc_bank0 spc_bank0_monitor #(.STARTUP_CYC(STARTUP_CYC), .RETRY_CYC(RETRY_CYC))
	u_spc_bank0_monitor (.mclk(mclk), .nrst(nrst), .ov_in(ov_in), .drv_on(drv_on),
	.control_word_1(control_word_1), .control_word_1_wr(control_word_1_wr),
	.status_clear(status_clear), .status_word_0(status_word_0));

// *** verif/spc_host_model.sv ***
// host side serial master model for the bank 0 frame link
`timescale 1ns/1ps
module spc_host_model (
	output logic      frame_select_low,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo_o,
	input  wire logic sdo_oe
);
	// ==========================================================
	// frame engine
	initial begin
		frame_select_low = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// sclk stands low between frames; 7 ns offset keeps it off the mclk grid
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'hffff;
		#7 frame_select_low = 1'b0;
		#100;
		for (int i = 0; i < n; i++) begin
			sdi = w[i];
			#100 sclk = 1'b1;
			// sample mid-high: the previous fall has long settled through the sync
			#50 r[i] = sdo_oe ? sdo_o : 1'bz;
			#50 sclk = 1'b0;
		end
		#100 frame_select_low = 1'b1;
		sdi = ~sdi;
		#200;
	endtask
endmodule // spc_host_model

// *** verif/test_spc_bank0.sv ***
// self-checking bench for the bank 0 control/status registers
`timescale 1ns/1ps
module test_spc_bank0
	import spc_pkg::*;
;
	localparam logic [15:0] D  = 16'h0184;
	localparam int          RT = 64;
	logic               mclk = 1'b0, nrst = 1'b0, pwm_in = 1'b1, active_req = 1'b0;
	logic               ov_in = 1'b0, uv_in = 1'b0, tsd_in = 1'b0, warn_in = 1'b0;
	logic [NUM_DRV-1:0] oc_in = '0, pwm_enable = '0, retry_enable = '0, drv_on;
	logic [15:0]        status_word_1 = 16'h8000, control_word_1, status_word_0, rd;
	logic               frame_select_low, sclk, sdi, sdo_o, sdo_oe, status_clear, cw1_wr;
	logic [CM_W-1:0]    current_image_pin;
	int                 fail_count = 0, checked = 0, n;

	always #12.5 mclk = ~mclk;

	spc_host_model u_spc_host_model (.frame_select_low(frame_select_low), .sclk(sclk),
		.sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
	spc_bank0 #(.STARTUP_CYC(16), .RETRY_CYC(RT)) u_spc_bank0 (.mclk(mclk), .nrst(nrst),
		.frame_select_low(frame_select_low), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe), .pwm_in(pwm_in), .active_req(active_req), .ov_in(ov_in),
		.uv_in(uv_in), .tsd_in(tsd_in), .warn_in(warn_in), .oc_in(oc_in),
		.pwm_enable(pwm_enable), .retry_enable(retry_enable), .status_word_1(status_word_1),
		.drv_on(drv_on), .current_image_pin(current_image_pin),
		.control_word_1(control_word_1), .control_word_1_wr(cw1_wr),
		.status_clear(status_clear), .status_word_0(status_word_0));

	// ==========================================================
	// tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// one full frame, returns on a clock edge so the next drive is an edge update
	task automatic wr(input logic [15:0] w);
		u_spc_host_model.xfer(w, 16, rd);
		@(posedge mclk);
	endtask
	task automatic wait_drv(input logic [7:0] e, input int lim);
		for (n = 0; n < lim && drv_on !== e; n++) cyc(1);
		chk({8'h00, drv_on}, {8'h00, e});
		if (drv_on !== e) complete_run();
	endtask

	// ==========================================================
	// sequence
	initial begin
		cyc(3);
		nrst <= 1'b1;
		cyc(4);
		wr(D);
		chk({8'h00, drv_on}, 16'h0000);
		active_req <= 1'b1;
		cyc(6);
		chk(status_word_0, 16'h8400);
		wait_drv(8'hc2, 40);
		wr(D);
		chk(rd, 16'h8001);
		// a 15-bit frame must leave control word 0 alone
		u_spc_host_model.xfer(16'h0000, 15, rd);
		@(posedge mclk);
		chk({8'h00, drv_on}, 16'h00c2);
		for (int i = 0; i < 8; i++) begin
			wr(16'h0002 << i);
			chk({8'h00, drv_on}, 16'h0001 << i);
			wr(D | 16'(i) << C_CM);
			chk(16'(current_image_pin), 16'(CM_MAP[3*i +: 3]));
		end
		wr(16'h0006);
		chk({8'h00, drv_on}, 16'h0000);
		wr(D);
		pwm_in <= 1'b0;
		pwm_enable <= 8'h40;
		wait_drv(8'h82, 8);
		pwm_in <= 1'b1;
		wait_drv(8'hc2, 8);
		pwm_enable <= 8'h00;
		warn_in <= 1'b1;
		cyc(6);
		chk(status_word_0, 16'h8800);
		chk({8'h00, drv_on}, 16'h00c2);
		warn_in <= 1'b0;
		wr(D | 16'h8000);
		chk(status_word_0, 16'h8001);
		uv_in <= 1'b1;
		wait_drv(8'h00, 10);
		// the status copy lands one edge after the driver register
		cyc(1);
		chk(status_word_0 & 16'h6000, 16'h2000);
		uv_in <= 1'b0;
		wait_drv(8'hc2, 10);
		// f = 1 supply overvoltage, f = 2 thermal trip, both with recovery disabled
		for (int f = 1; f < 3; f++) begin
			wr(D | 16'h9000);
			{tsd_in, ov_in} <= 2'(f);
			wait_drv(8'h00, 10);
			{tsd_in, ov_in} <= 2'b00;
			cyc(20);
			chk({8'h00, drv_on}, 16'h0000);
			chk(status_word_0 & 16'h5000, f == 1 ? 16'h4000 : 16'h1000);
			wr(D | 16'h9000);
			wait_drv(8'hc2, 10);
		end
		oc_in <= 8'h40;
		wait_drv(8'h82, 10);
		oc_in <= 8'h00;
		cyc(2 * RT);
		chk(status_word_0 & 16'h0080, 16'h0080);
		chk({8'h00, drv_on}, 16'h0082);
		retry_enable <= 8'h40;
		// off time is 7/8 of the period at low duty, 3/4 at high duty
		for (int k = 0; k < 3; k++) begin
			wr(D | 16'h8000 | 16'(k > 0) << C_DUTY);
			warn_in <= (k == 2);
			cyc(6);
			chk({8'h00, drv_on}, 16'h00c2);
			oc_in <= 8'h40;
			wait_drv(8'h82, 10);
			oc_in <= 8'h00;
			wait_drv(8'hc2, 2 * RT);
			chk(16'(n > 51), 16'(k != 1));
			warn_in <= 1'b0;
			cyc(4);
		end
		wr(D | 16'h8000);
		status_word_1 <= 16'h8003;
		cyc(4);
		chk(status_word_0 & 16'h0001, 16'h0000);
		wr(D | 16'hc000);
		chk(status_word_0 & 16'h0001, 16'h0001);
		wr(16'h0035);
		chk(rd, 16'h8003);
		chk(control_word_1, 16'h0035);
		complete_run();
	end
endmodule // test_spc_bank0
